// [mies_core.sv]
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module mies_core
   import mies_pkg::*;
#(
   parameter int unsigned WDT_WIDTH   = WDT_W,
   parameter int unsigned PRESC_WIDTH = PRESC_W
)
(
   input  wire logic              i_core_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_exec,
   input  wire logic [OP_W-1:0]   i_op,
   input  wire logic [DATA_W-1:0] i_literal,
   input  wire logic [FADDR_W-1:0] i_file_addr,
   input  wire logic              i_dest,
   input  wire logic              i_call,
   input  wire logic [PC_W-1:0]   i_call_target,
   input  wire logic              i_wake,
   input  wire logic [BUS_AW-1:0] i_bus_addr,
   input  wire logic [DATA_W-1:0] i_bus_wdata,
   input  wire logic              i_bus_we,
   input  wire logic              i_bus_re,
   output logic      [DATA_W-1:0] o_bus_rdata,
   output logic                   o_ready,
   output logic      [PC_W-1:0]   o_pc,
   output logic      [DATA_W-1:0] o_accum,
   output logic                   o_carry,
   output logic                   o_digit_carry_flag,
   output logic                   o_zero,
   output logic                   o_timeout_flag,
   output logic                   o_powerdown_flag,
   output logic                   o_global_interrupt_enable,
   output logic                   o_sleep,
   output logic                   o_osc_run
);

   mies_state_e state_q;
   mies_state_e state_d;

   logic [DATA_W-1:0] file_mem [2**FADDR_W];

   logic [PC_W-1:0]        pc_q;
   logic [PC_W-1:0]        pc_d;
   logic [DATA_W-1:0]      accum_q;
   logic [DATA_W-1:0]      accum_d;
   logic                   carry_q;
   logic                   carry_d;
   logic                   digit_q;
   logic                   digit_d;
   logic                   zero_q;
   logic                   zero_d;
   logic                   tout_q;
   logic                   tout_d;
   logic                   pdown_q;
   logic                   pdown_d;
   logic                   gie_q;
   logic                   gie_d;
   logic [WDT_WIDTH-1:0]   wdt_q;
   logic [WDT_WIDTH-1:0]   wdt_d;
   logic [PRESC_WIDTH-1:0] presc_q;
   logic [PRESC_WIDTH-1:0] presc_d;
   logic [DATA_W-1:0]      rdata_q;
   logic [DATA_W-1:0]      rdata_d;
   logic                   wake_meta_q;
   logic                   wake_sync_q;

   logic                   accept;
   logic                   call_take;
   logic                   is_return;
   logic                   is_sleep;
   logic                   lit_src;
   logic [DATA_W-1:0]      file_rd;
   logic [DATA_W-1:0]      alu_src;
   logic [DATA_W-1:0]      alu_result;
   logic                   alu_carry;
   logic                   alu_digit;
   logic                   alu_zero;
   logic                   upd_carry;
   logic                   upd_digit;
   logic                   upd_zero;
   logic                   to_accum;
   logic                   to_file;
   logic                   instr_file_we;
   logic                   bus_file_we;
   logic                   bus_is_file;
   logic [FADDR_W-1:0]     mem_waddr;
   logic [DATA_W-1:0]      mem_wdata;
   logic [PC_W-1:0]        pc_next;
   logic [PC_W-1:0]        stack_top;
   logic [DATA_W-1:0]      status_rd;
   logic [DATA_W-1:0]      wdt_rd;
   logic [DATA_W-1:0]      read_mux;
   logic                   bus_wr_status;

   // Instructions are taken only while running; returns hold the core one extra cycle.
   assign accept    = i_exec && (state_q == ST_RUN);
   assign call_take = i_call && !i_exec && (state_q == ST_RUN);
   assign is_return = accept && ((i_op == OP_INT_RETURN) || (i_op == OP_LIT_RETURN) ||
                                 (i_op == OP_SUB_RETURN));
   assign is_sleep  = accept && (i_op == OP_POWER_DOWN);
   assign lit_src   = (i_op == OP_LOAD_LIT) || (i_op == OP_LIT_RETURN) ||
                      (i_op == OP_LIT_SUB) || (i_op == OP_LIT_XOR);
   assign file_rd   = file_mem[i_file_addr];
   assign alu_src   = lit_src ? i_literal : file_rd;
   assign pc_next   = pc_q + PC_W'(1);

   mies_alu u_alu (
      .i_op          (i_op),
      .i_src         (alu_src),
      .i_accum       (accum_q),
      .i_carry       (carry_q),
      .i_dest        (i_dest),
      .o_result      (alu_result),
      .o_carry       (alu_carry),
      .o_digit_carry (alu_digit),
      .o_zero        (alu_zero),
      .o_upd_carry   (upd_carry),
      .o_upd_digit   (upd_digit),
      .o_upd_zero    (upd_zero),
      .o_to_accum    (to_accum),
      .o_to_file     (to_file)
   );

   mies_stack #(
      .DEPTH (STACK_D)
   ) u_stack (
      .i_core_clk  (i_core_clk),
      .i_sys_rst   (i_sys_rst),
      .i_push      (call_take),
      .i_push_addr (pc_next),
      .i_pop       (is_return),
      .o_top       (stack_top)
   );

   // An instruction write to the file wins over a bus write in the same cycle.
   assign instr_file_we = accept && to_file;
   assign bus_is_file   = (i_bus_addr <= ADDR_FILE_TOP);
   assign bus_file_we   = i_bus_we && bus_is_file && !instr_file_we;
   assign mem_waddr     = instr_file_we ? i_file_addr : i_bus_addr[FADDR_W-1:0];
   assign mem_wdata     = instr_file_we ? alu_result : i_bus_wdata;
   assign bus_wr_status = i_bus_we && (i_bus_addr == ADDR_STATUS);

   always_ff @(posedge i_core_clk) begin
      if (instr_file_we || bus_file_we) begin
         file_mem[mem_waddr] <= mem_wdata;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (is_return) begin
               state_d = ST_RET2;
            end else if (is_sleep) begin
               state_d = ST_SLEEP;
            end
         end
         ST_RET2: state_d = ST_RUN;
         ST_SLEEP: begin
            if (wake_sync_q) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   always_comb begin
      pc_d = pc_q;
      if (is_return) begin
         pc_d = stack_top;
      end else if (call_take) begin
         pc_d = i_call_target;
      end else if (accept) begin
         pc_d = pc_next;
      end
   end

   assign accum_d = (accept && to_accum) ? alu_result :
                    (i_bus_we && (i_bus_addr == ADDR_ACCUM)) ? i_bus_wdata : accum_q;

   assign carry_d = (accept && upd_carry) ? alu_carry :
                    bus_wr_status ? i_bus_wdata[ST_CARRY_BIT] : carry_q;
   assign digit_d = (accept && upd_digit) ? alu_digit :
                    bus_wr_status ? i_bus_wdata[ST_DIGIT_BIT] : digit_q;
   assign zero_d  = (accept && upd_zero) ? alu_zero :
                    bus_wr_status ? i_bus_wdata[ST_ZERO_BIT] : zero_q;
   assign tout_d  = is_sleep ? 1'b1 : tout_q;
   assign pdown_d = is_sleep ? 1'b0 : pdown_q;

   assign gie_d = (accept && (i_op == OP_INT_RETURN)) ? 1'b1 :
                  (i_bus_we && (i_bus_addr == ADDR_CONTROL)) ? i_bus_wdata[CTL_GIE_BIT] :
                  gie_q;

   // The watchdog ticks once per prescaler wrap; it stands still in sleep.
   always_comb begin
      presc_d = presc_q;
      wdt_d   = wdt_q;
      if (is_sleep) begin
         presc_d = '0;
         wdt_d   = '0;
      end else if (state_q != ST_SLEEP) begin
         presc_d = presc_q + PRESC_WIDTH'(1);
         if (presc_q == '1) begin
            wdt_d = wdt_q + WDT_WIDTH'(1);
         end
      end
   end

   assign status_rd = {2'b00, (state_q == ST_SLEEP), tout_q, pdown_q, zero_q, digit_q,
                       carry_q};
   assign wdt_rd    = DATA_W'(wdt_q);
   assign read_mux  = bus_is_file                  ? file_mem[i_bus_addr[FADDR_W-1:0]] :
                      (i_bus_addr == ADDR_ACCUM)    ? accum_q :
                      (i_bus_addr == ADDR_STATUS)   ? status_rd :
                      (i_bus_addr == ADDR_PC_LO)    ? pc_q[7:0] :
                      (i_bus_addr == ADDR_PC_HI)    ? {3'b000, pc_q[PC_W-1:8]} :
                      (i_bus_addr == ADDR_WATCHDOG) ? wdt_rd :
                      (i_bus_addr == ADDR_CONTROL)  ? {7'h00, gie_q} : 8'h00;
   assign rdata_d   = i_bus_re ? read_mux : 8'h00;

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wake_meta_q <= 1'b0;
         wake_sync_q <= 1'b0;
      end else begin
         wake_meta_q <= i_wake;
         wake_sync_q <= wake_meta_q;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= ST_RUN;
         pc_q    <= RST_PC;
         accum_q <= RST_ACCUM;
         gie_q   <= RST_GIE;
      end else begin
         state_q <= state_d;
         pc_q    <= pc_d;
         accum_q <= accum_d;
         gie_q   <= gie_d;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         carry_q <= 1'b0;
         digit_q <= 1'b0;
         zero_q  <= 1'b0;
         tout_q  <= RST_TOUT;
         pdown_q <= RST_PDOWN;
      end else begin
         carry_q <= carry_d;
         digit_q <= digit_d;
         zero_q  <= zero_d;
         tout_q  <= tout_d;
         pdown_q <= pdown_d;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         presc_q <= PRESC_CLEAR;
         wdt_q   <= WDT_CLEAR;
         rdata_q <= 8'h00;
      end else begin
         presc_q <= presc_d;
         wdt_q   <= wdt_d;
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_ready   <= 1'b1;
         o_sleep   <= 1'b0;
         o_osc_run <= 1'b1;
      end else begin
         o_ready   <= (state_d == ST_RUN);
         o_sleep   <= (state_d == ST_SLEEP);
         o_osc_run <= (state_d != ST_SLEEP);
      end
   end

   assign o_bus_rdata               = rdata_q;
   assign o_pc                      = pc_q;
   assign o_accum                   = accum_q;
   assign o_carry                   = carry_q;
   assign o_digit_carry_flag        = digit_q;
   assign o_zero                    = zero_q;
   assign o_timeout_flag            = tout_q;
   assign o_powerdown_flag          = pdown_q;
   assign o_global_interrupt_enable = gie_q;

endmodule : mies_core
`default_nettype wire

// [mies_pkg.sv]
package mies_pkg;

   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FADDR_W    = 7;
   localparam int unsigned PC_W       = 13;
   localparam int unsigned OP_W       = 4;
   localparam int unsigned BUS_AW     = 8;
   localparam int unsigned STACK_D    = 8;
   localparam int unsigned WDT_W      = 8;
   localparam int unsigned PRESC_W    = 7;

   localparam logic [OP_W-1:0] OP_NOP         = 4'h0;
   localparam logic [OP_W-1:0] OP_LOAD_LIT    = 4'h1;
   localparam logic [OP_W-1:0] OP_STORE_ACC   = 4'h2;
   localparam logic [OP_W-1:0] OP_INT_RETURN  = 4'h3;
   localparam logic [OP_W-1:0] OP_LIT_RETURN  = 4'h4;
   localparam logic [OP_W-1:0] OP_SUB_RETURN  = 4'h5;
   localparam logic [OP_W-1:0] OP_ROTATE_LEFT = 4'h6;
   localparam logic [OP_W-1:0] OP_ROTATE_RGHT = 4'h7;
   localparam logic [OP_W-1:0] OP_LIT_SUB     = 4'h8;
   localparam logic [OP_W-1:0] OP_FILE_SUB    = 4'h9;
   localparam logic [OP_W-1:0] OP_NIBBLE_SWAP = 4'hA;
   localparam logic [OP_W-1:0] OP_FILE_XOR    = 4'hB;
   localparam logic [OP_W-1:0] OP_LIT_XOR     = 4'hC;
   localparam logic [OP_W-1:0] OP_POWER_DOWN  = 4'hD;

   // Register map: file registers fill 00h to 7Fh, core registers follow.
   localparam logic [BUS_AW-1:0] ADDR_FILE_TOP = 8'h7F;
   localparam logic [BUS_AW-1:0] ADDR_ACCUM    = 8'h80;
   localparam logic [BUS_AW-1:0] ADDR_STATUS   = 8'h81;
   localparam logic [BUS_AW-1:0] ADDR_PC_LO    = 8'h82;
   localparam logic [BUS_AW-1:0] ADDR_PC_HI    = 8'h83;
   localparam logic [BUS_AW-1:0] ADDR_WATCHDOG = 8'h84;
   localparam logic [BUS_AW-1:0] ADDR_CONTROL  = 8'h85;

   localparam int unsigned ST_CARRY_BIT   = 0;
   localparam int unsigned ST_DIGIT_BIT   = 1;
   localparam int unsigned ST_ZERO_BIT    = 2;
   localparam int unsigned ST_PDOWN_BIT   = 3;
   localparam int unsigned ST_TOUT_BIT    = 4;
   localparam int unsigned ST_SLEEP_BIT   = 5;
   localparam int unsigned CTL_GIE_BIT    = 0;

   localparam logic             RST_PDOWN   = 1'b1;
   localparam logic             RST_TOUT    = 1'b1;
   localparam logic             RST_GIE     = 1'b0;
   localparam logic [PC_W-1:0]  RST_PC      = 13'h0000;
   localparam logic [DATA_W-1:0] RST_ACCUM  = 8'h00;
   localparam logic [WDT_W-1:0] WDT_CLEAR   = 8'h00;
   localparam logic [PRESC_W-1:0] PRESC_CLEAR = 7'h00;

   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_RET2  = 3'b010,
      ST_SLEEP = 3'b100
   } mies_state_e;

endpackage : mies_pkg

// [mies_alu.sv]
`timescale 1ns/10ps
`default_nettype none
module mies_alu
   import mies_pkg::*;
(
   input  wire logic [OP_W-1:0]   i_op,
   input  wire logic [DATA_W-1:0] i_src,
   input  wire logic [DATA_W-1:0] i_accum,
   input  wire logic              i_carry,
   input  wire logic              i_dest,
   output logic      [DATA_W-1:0] o_result,
   output logic                   o_carry,
   output logic                   o_digit_carry,
   output logic                   o_zero,
   output logic                   o_upd_carry,
   output logic                   o_upd_digit,
   output logic                   o_upd_zero,
   output logic                   o_to_accum,
   output logic                   o_to_file
);

   logic [DATA_W:0] diff;
   logic [4:0]      diff_lo;
   logic            routed;

   assign diff    = {1'b0, i_src} - {1'b0, i_accum};
   assign diff_lo = {1'b0, i_src[3:0]} - {1'b0, i_accum[3:0]};
   assign routed  = (i_op == OP_ROTATE_LEFT) || (i_op == OP_ROTATE_RGHT) ||
                    (i_op == OP_FILE_SUB) || (i_op == OP_NIBBLE_SWAP) ||
                    (i_op == OP_FILE_XOR);

   always_comb begin
      o_result    = i_src;
      o_carry     = i_carry;
      o_upd_carry = 1'b0;
      o_upd_digit = 1'b0;
      o_upd_zero  = 1'b0;
      case (i_op)
         OP_LOAD_LIT,
         OP_LIT_RETURN: o_result = i_src;
         OP_STORE_ACC: o_result = i_accum;
         OP_ROTATE_LEFT: begin
            o_result    = {i_src[DATA_W-2:0], i_carry};
            o_carry     = i_src[DATA_W-1];
            o_upd_carry = 1'b1;
         end
         OP_ROTATE_RGHT: begin
            o_result    = {i_carry, i_src[DATA_W-1:1]};
            o_carry     = i_src[0];
            o_upd_carry = 1'b1;
         end
         OP_LIT_SUB,
         OP_FILE_SUB: begin
            o_result    = diff[DATA_W-1:0];
            o_carry     = ~diff[DATA_W];
            o_upd_carry = 1'b1;
            o_upd_digit = 1'b1;
            o_upd_zero  = 1'b1;
         end
         OP_NIBBLE_SWAP: o_result = {i_src[3:0], i_src[7:4]};
         OP_FILE_XOR,
         OP_LIT_XOR: begin
            o_result   = i_src ^ i_accum;
            o_upd_zero = 1'b1;
         end
         default: o_result = i_src;
      endcase
   end

   assign o_digit_carry = ~diff_lo[4];
   assign o_zero        = (o_result == '0);
   assign o_to_file     = (i_op == OP_STORE_ACC) || (routed && i_dest);
   assign o_to_accum    = (routed && !i_dest) || (i_op == OP_LOAD_LIT) ||
                          (i_op == OP_LIT_RETURN) || (i_op == OP_LIT_SUB) ||
                          (i_op == OP_LIT_XOR);

endmodule : mies_alu
`default_nettype wire

// [mies_stack.sv]
`timescale 1ns/10ps
`default_nettype none
module mies_stack
   import mies_pkg::*;
#(
   parameter int unsigned DEPTH = STACK_D
)
(
   input  wire logic            i_core_clk,
   input  wire logic            i_sys_rst,
   input  wire logic            i_push,
   input  wire logic [PC_W-1:0] i_push_addr,
   input  wire logic            i_pop,
   output logic      [PC_W-1:0] o_top
);

   localparam int unsigned PTR_W = $clog2(DEPTH);

   // The stack is circular: a ninth push silently overwrites the oldest entry.
   logic [PC_W-1:0]  entry [DEPTH];
   logic [PTR_W-1:0] ptr_q;
   logic [PTR_W-1:0] ptr_d;
   logic [PTR_W-1:0] ptr_top;

   assign ptr_top = ptr_q - PTR_W'(1);
   assign o_top   = entry[ptr_top];
   assign ptr_d   = i_push ? ptr_q + PTR_W'(1) : (i_pop ? ptr_top : ptr_q);

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ptr_q <= '0;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_push) begin
         entry[ptr_q] <= i_push_addr;
      end
   end

endmodule : mies_stack
`default_nettype wire

// [mies_core_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module mies_core_monitor
   import mies_pkg::*;
(
   input wire logic              i_core_clk,
   input wire logic              i_sys_rst,
   input wire logic              i_exec,
   input wire logic [OP_W-1:0]   i_op,
   input wire logic [DATA_W-1:0] i_literal,
   input wire logic              i_dest,
   input wire logic              o_ready,
   input wire logic [PC_W-1:0]   o_pc,
   input wire logic [DATA_W-1:0] o_accum,
   input wire logic              o_carry,
   input wire logic              o_digit_carry_flag,
   input wire logic              o_zero,
   input wire logic              o_timeout_flag,
   input wire logic              o_powerdown_flag,
   input wire logic              o_global_interrupt_enable,
   input wire logic              o_sleep,
   input wire logic              o_osc_run
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   wire logic       tk;
   wire logic [2:0] flg;
   wire logic [1:0] cd;
   wire logic       ret;
   wire logic       fdst;
   assign tk   = i_exec && o_ready;
   assign flg  = {o_zero, o_digit_carry_flag, o_carry};
   assign cd   = {o_digit_carry_flag, o_carry};
   assign ret  = tk && (i_op inside {OP_INT_RETURN, OP_LIT_RETURN, OP_SUB_RETURN});
   assign fdst = tk && i_dest && (i_op inside {OP_ROTATE_LEFT, OP_ROTATE_RGHT, OP_FILE_SUB,
                                               OP_NIBBLE_SWAP, OP_FILE_XOR});
   chk_load_lit: assert property (tk && i_op == OP_LOAD_LIT |=>
      o_accum == $past(i_literal) && flg == $past(flg)) else $error("load literal wrong");
   chk_xor_lit: assert property (tk && i_op == OP_LIT_XOR |=>
      o_accum == ($past(i_literal) ^ $past(o_accum)) && o_zero == (o_accum == 8'h00)
      && cd == $past(cd)) else $error("literal xor wrong");
   chk_sub_lit: assert property (tk && i_op == OP_LIT_SUB |=>
      o_accum == $past(i_literal) - $past(o_accum) && o_zero == (o_accum == 8'h00)
      && o_carry == ($past(i_literal) >= $past(o_accum))) else $error("literal sub wrong");
   chk_ret_gap: assert property (ret |=> !o_ready ##1 o_ready)
      else $error("return cycle count wrong");
   chk_int_ret: assert property (tk && i_op == OP_INT_RETURN |=>
      o_global_interrupt_enable && flg == $past(flg)) else $error("interrupt return wrong");
   chk_pdown_flags: assert property (tk && i_op == OP_POWER_DOWN |=>
      o_timeout_flag && !o_powerdown_flag && o_sleep && !o_osc_run)
      else $error("power-down entry wrong");
   chk_sleep_halt: assert property (o_sleep |-> !o_ready && !o_osc_run)
      else $error("sleep without halt");
   chk_nop_still: assert property (tk && i_op == OP_NOP |=>
      o_pc == $past(o_pc) + 13'h1 && o_accum == $past(o_accum) && flg == $past(flg))
      else $error("nop changed state");
   chk_rot_left: assert property (tk && i_op == OP_ROTATE_LEFT && !i_dest |=>
      o_accum[0] == $past(o_carry)) else $error("rotate left carry in wrong");
   chk_rot_right: assert property (tk && i_op == OP_ROTATE_RGHT && !i_dest |=>
      o_accum[7] == $past(o_carry)) else $error("rotate right carry in wrong");
   chk_file_dest: assert property (fdst |=> o_accum == $past(o_accum))
      else $error("file destination touched accumulator");
   cov_pdown: cover property (tk && i_op == OP_POWER_DOWN);
   cov_ret: cover property (ret);
   cov_sub_zero: cover property (tk && i_op == OP_LIT_SUB ##1 o_zero);
endmodule : mies_core_monitor

bind mies_core mies_core_monitor u_mon (.i_core_clk, .i_sys_rst, .i_exec, .i_op, .i_literal,
   .i_dest, .o_ready, .o_pc, .o_accum, .o_carry, .o_digit_carry_flag, .o_zero,
   .o_timeout_flag, .o_powerdown_flag, .o_global_interrupt_enable, .o_sleep, .o_osc_run);
`default_nettype wire

// [mies_core_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module mies_core_tb_top
   import mies_pkg::*;
;
   typedef struct packed {
      logic [3:0] op;
      logic [7:0] v;
      logic       d;
      logic [7:0] a;
      logic [2:0] s;
      logic [7:0] r;
      logic [2:0] e;
   } mies_row_s;
   // Columns: op, file or literal value, dest, start accum, start {z,dc,c}, result, end flags.
   localparam mies_row_s ROWS [19] = '{
      {OP_LOAD_LIT, 8'hA5, 1'h0, 8'h3C, 3'h7, 8'hA5, 3'h7},
      {OP_LOAD_LIT, 8'h00, 1'h0, 8'hFF, 3'h0, 8'h00, 3'h0},
      {OP_STORE_ACC, 8'h11, 1'h1, 8'h5A, 3'h5, 8'h5A, 3'h5},
      {OP_LIT_XOR, 8'hFF, 1'h0, 8'h0F, 3'h0, 8'hF0, 3'h0},
      {OP_LIT_XOR, 8'h5A, 1'h0, 8'h5A, 3'h3, 8'h00, 3'h7},
      {OP_LIT_SUB, 8'h10, 1'h0, 8'h01, 3'h6, 8'h0F, 3'h1},
      {OP_LIT_SUB, 8'h05, 1'h0, 8'h05, 3'h0, 8'h00, 3'h7},
      {OP_LIT_SUB, 8'h01, 1'h0, 8'h02, 3'h7, 8'hFF, 3'h0},
      {OP_FILE_SUB, 8'h20, 1'h0, 8'h01, 3'h0, 8'h1F, 3'h1},
      {OP_FILE_SUB, 8'h33, 1'h1, 8'h11, 3'h0, 8'h22, 3'h3},
      {OP_ROTATE_LEFT, 8'h81, 1'h0, 8'h00, 3'h0, 8'h02, 3'h1},
      {OP_ROTATE_LEFT, 8'h40, 1'h1, 8'h00, 3'h5, 8'h81, 3'h4},
      {OP_ROTATE_RGHT, 8'h01, 1'h0, 8'h00, 3'h0, 8'h00, 3'h1},
      {OP_ROTATE_RGHT, 8'h02, 1'h1, 8'h00, 3'h1, 8'h81, 3'h0},
      {OP_NIBBLE_SWAP, 8'hA5, 1'h0, 8'h00, 3'h2, 8'h5A, 3'h2},
      {OP_NIBBLE_SWAP, 8'h3C, 1'h1, 8'h00, 3'h0, 8'hC3, 3'h0},
      {OP_FILE_XOR, 8'hF0, 1'h0, 8'hFF, 3'h0, 8'h0F, 3'h0},
      {OP_FILE_XOR, 8'h77, 1'h1, 8'h77, 3'h3, 8'h00, 3'h7},
      {OP_NOP, 8'h00, 1'h0, 8'h42, 3'h5, 8'h42, 3'h5}
   };
   logic        clk  = 1'b0;
   logic        rst  = 1'b1;
   logic        exec = 1'b0;
   logic [3:0]  op   = 4'h0;
   logic [7:0]  lit  = 8'h00;
   logic        dest = 1'b0;
   logic [6:0]  fa   = 7'h7F;
   logic        call = 1'b0;
   logic [12:0] tgt  = 13'h0000;
   logic        wake = 1'b0;
   logic [7:0]  ba   = 8'h00;
   logic [7:0]  bw   = 8'h00;
   logic        we   = 1'b0;
   logic        re   = 1'b0;
   logic [7:0]  d;
   logic [12:0] p;
   int          err_count  = 0;
   int          num_checks = 0;
   int          cyc        = 0;
   wire logic [7:0]  rdata;
   wire logic        ready;
   wire logic [12:0] pc;
   wire logic [7:0]  acc;
   wire logic        c;
   wire logic        dc;
   wire logic        z;
   wire logic        to;
   wire logic        pd;
   wire logic        global_interrupt_enable;
   wire logic        slp;
   wire logic        osc;
   mies_core dut (.i_core_clk(clk), .i_sys_rst(rst), .i_exec(exec), .i_op(op), .i_literal(lit),
      .i_file_addr(fa), .i_dest(dest), .i_call(call), .i_call_target(tgt), .i_wake(wake),
      .i_bus_addr(ba), .i_bus_wdata(bw), .i_bus_we(we), .i_bus_re(re), .o_bus_rdata(rdata),
      .o_ready(ready), .o_pc(pc), .o_accum(acc), .o_carry(c), .o_digit_carry_flag(dc),
      .o_zero(z), .o_timeout_flag(to), .o_powerdown_flag(pd), .o_global_interrupt_enable(global_interrupt_enable),
      .o_sleep(slp), .o_osc_run(osc));
   always #12.5 clk = ~clk;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) begin we <= 1'b1; ba <= a; bw <= v; end
      @(posedge clk) we <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk) begin re <= 1'b1; ba <= a; end
      @(posedge clk) re <= 1'b0;
      #1 v = rdata;
   endtask : bus_rd
   task automatic do_op(input logic [3:0] o, input logic [7:0] l, input logic dd);
      @(posedge clk) begin exec <= 1'b1; op <= o; lit <= l; dest <= dd; end
      @(posedge clk) exec <= 1'b0;
      #1;
   endtask : do_op
   task automatic do_call(input logic [12:0] t);
      @(posedge clk) begin call <= 1'b1; tgt <= t; end
      @(posedge clk) call <= 1'b0;
   endtask : do_call
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 19; k++) begin
         bus_wr(ADDR_FILE_TOP, ROWS[k].v);
         bus_wr(ADDR_ACCUM, ROWS[k].a);
         bus_wr(ADDR_STATUS, {5'h00, ROWS[k].s});
         do_op(ROWS[k].op, ROWS[k].v, ROWS[k].d);
         if (ROWS[k].d) begin
            check("accum", acc, ROWS[k].a);
            bus_rd(ADDR_FILE_TOP, d);
            check("file", d, ROWS[k].r);
         end else check("accum", acc, ROWS[k].r);
         check("flags", {z, dc, c}, ROWS[k].e);
      end
      p = pc;
      do_call(13'h0100);
      do_call(13'h0200);
      do_call(13'h0300);
      do_op(OP_LIT_RETURN, 8'h77, 1'b0);
      check("pc", pc, 13'h0201);
      check("accum", acc, 8'h77);
      check("ready", ready, 1'b0);
      do_op(OP_SUB_RETURN, 8'h00, 1'b0);
      check("pc", pc, 13'h0101);
      check("ready", ready, 1'b0);
      do_op(OP_INT_RETURN, 8'h00, 1'b0);
      check("pc", pc, p + 13'h1);
      check("gie", global_interrupt_enable, 1'b1);
      do_op(OP_POWER_DOWN, 8'h00, 1'b0);
      check("sleep", {slp, osc, to, pd}, 4'hA);
      bus_rd(ADDR_WATCHDOG, d);
      check("watchdog", d, 8'h00);
      do_op(OP_LOAD_LIT, 8'h99, 1'b0);
      check("accum", acc, 8'h77);
      @(posedge clk) wake <= 1'b1;
      for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk);
      wake <= 1'b0;
      #1 check("osc", {osc, slp}, 2'h2);
      bus_rd(8'hF0, d);
      check("unmapped", d, 8'h00);
      bus_rd(ADDR_ACCUM, d);
      check("rd accum", d, 8'h77);
      @(posedge clk) fa <= 7'h05;
      do_op(OP_STORE_ACC, 8'h00, 1'b0);
      bus_rd(8'h05, d);
      check("file 05", d, 8'h77);
      bus_rd(ADDR_FILE_TOP, d);
      check("file 7F", d, 8'h00);
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      #1 check("reset", {pc, acc, to, pd, global_interrupt_enable}, {13'h0000, 8'h00, 3'h6});
      tally_and_finish();
   end
endmodule : mies_core_tb_top
`default_nettype wire
